// file: core/spm_pkg.sv
// Purpose: constants and types for the protection map command block
// Assumes: spi mode 0, msb first, one byte per eight serial clocks
// Notes: link side runs on the serial clock, map side on clk
//
// Overview of operation
// - sixteen map bytes, byte n steers protection of sector n
// - sectors one to fifteen: FFh protected, 00h unprotected
// - sector zero: bits 7:6 guard first subsector, bits 5:4 second
// - every map byte starts at 00h, all sectors unprotected
// - erase sequence 3Dh 2Ah 7Fh CFh, then chip select rise starts erase
// - ready flag low during erase, finished within the map erase time
// - erase sets every map byte to FFh
// - erase and program accepted with protection enabled or disabled
// - program sequence 3Dh 2Ah 7Fh FCh plus sixteen bytes, busy until done
// - bytes not sent before chip select rise leave sectors undefined
// - data beyond sixteen bytes wraps to location zero
// - program uses data buffer one as staging, overwriting it
// - opcode 32h plus three dummy bytes, then map bytes 0..15 shift out
// - clocks past the sixteenth byte give undefined data
// - chip select rise ends the read and floats serial out
// - lockdown 3Dh 2Ah 7Fh 30h plus three address bytes, busy while running
// - locked sectors stay blocked forever, nothing unlocks them; here arst_n clears locked
// - write protect pin asserted refuses map erase and program
// - map marks block sectors only while protection is enabled
package spm_pkg;
  localparam logic [7:0] OP_PREFIX0 = 8'h3D;
  localparam logic [7:0] OP_PREFIX1 = 8'h2A;
  localparam logic [7:0] OP_PREFIX2 = 8'h7F;
  localparam logic [7:0] OP_ERASE = 8'hCF;
  localparam logic [7:0] OP_PROGRAM = 8'hFC;
  localparam logic [7:0] OP_LOCK = 8'h30;
  localparam logic [7:0] OP_READ = 8'h32;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] MAP_ERASED = 8'hFF;
  localparam int MAP_BYTES = 16;
  localparam logic [5:0] HDR_BYTES = 6'h04;
  localparam logic [5:0] LOCK_LAST = 6'h06;
  localparam logic [4:0] DATA_MAX = 5'h10;
  localparam int SECTOR_LSB = 17;
  localparam int PAGE_LSB = 9;
  localparam logic [7:0] SUB0_PAGES = 8'h08;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam int CLK_HZ = 20_000_000;
  localparam int MAP_ERASE_TIME_US = 400;
  localparam int PROGRAM_CYCLE_TIME_US = 400;
  localparam int MAP_ERASE_CYCLES = MAP_ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_US * (CLK_HZ / 1_000_000);
  typedef enum logic [2:0] {
    CMD_NONE, CMD_ERASE, CMD_PROGRAM, CMD_LOCK_WAIT, CMD_LOCK, CMD_READ
  } link_cmd_t;
  typedef struct packed {
    logic [15:1] sector;
    logic second_subsector;
    logic first_subsector;
  } prot_view_t;
endpackage

// file: core/sector_protect_map_commands.sv
// Purpose: protection map erase, program, read and sector lockdown
// Assumes: sck stands still while cs_n is high
// Notes: map and lock state are volatile models of nonvolatile cells
module sector_protect_map_commands #(
  parameter int ERASE_CYCLES = spm_pkg::MAP_ERASE_CYCLES,
  parameter int PROG_CYCLES = spm_pkg::PROGRAM_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  input wire logic wp_n,
  input wire logic sw_protect_en,
  output logic ready,
  output spm_pkg::prot_view_t blocked,
  output spm_pkg::prot_view_t locked
);

  // link side, serial clock domain
  logic link_clr;
  logic [2:0] bit_cnt;
  logic [6:0] shin;
  logic [5:0] byte_cnt;
  logic hdr_ok;
  logic [7:0] rx;
  logic byte_done;
  spm_pkg::link_cmd_t link_cmd;
  logic [3:0] wr_idx;
  logic [4:0] data_cnt;
  logic [7:0] staging [spm_pkg::MAP_BYTES];
  logic [23:0] lock_addr;
  logic [7:0] map [spm_pkg::MAP_BYTES];
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;

  assign link_clr = cs_n | ~arst_n;
  assign rx = {shin, si};
  assign byte_done = (bit_cnt == 3'h7);
  assign rd_idx = byte_cnt - spm_pkg::HDR_BYTES;

  function automatic logic [7:0] prefix_byte(input logic [5:0] n);
    unique case (n)
      6'h00: prefix_byte = spm_pkg::OP_PREFIX0;
      6'h01: prefix_byte = spm_pkg::OP_PREFIX1;
      default: prefix_byte = spm_pkg::OP_PREFIX2;
    endcase
  endfunction

  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt <= 3'h0;
      shin <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shin <= rx[6:0];
    end
  end

  // byte counter saturates so long frames never wrap into the header
  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      byte_cnt <= 6'h00;
    end else if (byte_done && byte_cnt != 6'h3F) begin
      byte_cnt <= byte_cnt + 6'h01;
    end
  end

  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      hdr_ok <= 1'b1;
    end else if (byte_done && byte_cnt < 6'h03 && rx != prefix_byte(byte_cnt)) begin
      hdr_ok <= 1'b0;
    end
  end

  // command result survives the frame so the map side can act on it
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      link_cmd <= spm_pkg::CMD_NONE;
    end else if (byte_cnt == 6'h00 && bit_cnt == 3'h0) begin
      link_cmd <= spm_pkg::CMD_NONE;
    end else if (byte_done && byte_cnt == 6'h00) begin
      link_cmd <= (rx == spm_pkg::OP_READ) ? spm_pkg::CMD_READ : spm_pkg::CMD_NONE;
    end else if (byte_done && byte_cnt == 6'h03 && hdr_ok) begin
      unique case (rx)
        spm_pkg::OP_ERASE: link_cmd <= spm_pkg::CMD_ERASE;
        spm_pkg::OP_PROGRAM: link_cmd <= spm_pkg::CMD_PROGRAM;
        spm_pkg::OP_LOCK: link_cmd <= spm_pkg::CMD_LOCK_WAIT;
        default: link_cmd <= spm_pkg::CMD_NONE;
      endcase
    end else if (byte_done && byte_cnt == spm_pkg::LOCK_LAST
                 && link_cmd == spm_pkg::CMD_LOCK_WAIT) begin
      link_cmd <= spm_pkg::CMD_LOCK;
    end
  end

  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      wr_idx <= 4'h0;
      data_cnt <= 5'h00;
    end else if (byte_done && byte_cnt == 6'h03) begin
      wr_idx <= 4'h0;
      data_cnt <= 5'h00;
    end else if (byte_done && link_cmd == spm_pkg::CMD_PROGRAM) begin
      wr_idx <= wr_idx + 4'h1;
      if (data_cnt != spm_pkg::DATA_MAX) begin
        data_cnt <= data_cnt + 5'h01;
      end
    end
  end

  // staging area stands in for data buffer one
  always_ff @(posedge sck) begin
    if (byte_done && link_cmd == spm_pkg::CMD_PROGRAM) begin
      staging[wr_idx] <= rx;
    end
  end

  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      lock_addr <= 24'h000000;
    end else if (byte_done && link_cmd == spm_pkg::CMD_LOCK_WAIT) begin
      lock_addr <= {lock_addr[15:0], rx};
    end
  end

  // map is stable while a read frame runs, commits need cs_n high
  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx < 6'(spm_pkg::MAP_BYTES)) begin
      rd_byte = map[rd_idx[3:0]];
    end
  end

  always_ff @(negedge sck or posedge link_clr) begin
    if (link_clr) begin
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      so_oe_n <= ~(link_cmd == spm_pkg::CMD_READ && byte_cnt >= spm_pkg::HDR_BYTES);
      so <= rd_byte[~bit_cnt];
    end
  end

  // map side, clk domain
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_lvl;
  logic cs_prev;
  logic cs_rise;
  logic go;
  logic erase_go;
  logic prog_go;
  logic lock_go;
  logic wp_free;
  logic prot_en;
  logic [31:0] timer;
  logic [3:0] lock_sector;
  spm_pkg::prot_view_t next_blocked;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= spm_pkg::SYNC_RESET;
      pin_s2 <= spm_pkg::SYNC_RESET;
      pin_s3 <= spm_pkg::SYNC_RESET;
      pin_lvl <= spm_pkg::SYNC_RESET;
    end else begin
      pin_s1 <= {wp_n, cs_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= pin_lvl[0];
    end
  end

  assign cs_rise = pin_lvl[0] & ~cs_prev;
  assign wp_free = pin_lvl[1];
  assign go = cs_rise & ready;
  assign erase_go = go && link_cmd == spm_pkg::CMD_ERASE && wp_free;
  assign prog_go = go && link_cmd == spm_pkg::CMD_PROGRAM && wp_free;
  assign lock_go = go && link_cmd == spm_pkg::CMD_LOCK;
  assign prot_en = sw_protect_en | ~wp_free;
  assign lock_sector = lock_addr[spm_pkg::SECTOR_LSB +: 4];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < spm_pkg::MAP_BYTES; i++) begin
        map[i] <= spm_pkg::MAP_RESET;
      end
    end else if (erase_go) begin
      for (int i = 0; i < spm_pkg::MAP_BYTES; i++) begin
        map[i] <= spm_pkg::MAP_ERASED;
      end
    end else if (prog_go) begin
      for (int i = 0; i < spm_pkg::MAP_BYTES; i++) begin
        if (5'(i) < data_cnt) begin
          map[i] <= map[i] & staging[i];
        end
      end
    end
  end

  localparam int PAGE_END = spm_pkg::SECTOR_LSB - 1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      locked <= '0;
    end else if (lock_go) begin
      if (lock_sector != 4'h0) begin
        locked.sector[lock_sector] <= 1'b1;
      end else if (lock_addr[PAGE_END:spm_pkg::PAGE_LSB] < spm_pkg::SUB0_PAGES) begin
        locked.first_subsector <= 1'b1;
      end else begin
        locked.second_subsector <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready <= 1'b1;
      timer <= 32'h00000000;
    end else if (erase_go) begin
      ready <= 1'b0;
      timer <= 32'(ERASE_CYCLES - 1);
    end else if (prog_go || lock_go) begin
      ready <= 1'b0;
      timer <= 32'(PROG_CYCLES - 1);
    end else if (!ready) begin
      if (timer == 32'h00000000) begin
        ready <= 1'b1;
      end else begin
        timer <= timer - 32'h00000001;
      end
    end
  end

  always_comb begin
    next_blocked.first_subsector = locked.first_subsector
                                   | (prot_en & (&map[0][7:6]));
    next_blocked.second_subsector = locked.second_subsector
                                    | (prot_en & (&map[0][5:4]));
  end

  for (genvar s = 1; s < spm_pkg::MAP_BYTES; s++) begin : g_sector
    assign next_blocked.sector[s] = locked.sector[s]
                                    | (prot_en & map[s] == spm_pkg::MAP_ERASED);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blocked <= '0;
    end else begin
      blocked <= next_blocked;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_erase_start;
    erase_go;
  endsequence

  sequence s_busy_run;
    !ready [*8];
  endsequence

  sequence s_prog_start;
    prog_go;
  endsequence

  sequence s_lock_start;
    lock_go;
  endsequence

  sequence s_erase_request;
    cs_rise && ready && link_cmd == spm_pkg::CMD_ERASE && wp_free;
  endsequence

  a_erase_fills_map: assert property (s_erase_start |=> map[0] == 8'hFF && map[15] == 8'hFF)
    else $error("map erase did not set FFh");
  a_erase_busy: assert property (s_erase_start |=> s_busy_run)
    else $error("ready rose too early after erase");
  a_busy_bound: assert property (!ready |-> timer <= 32'(ERASE_CYCLES) || timer <= 32'(PROG_CYCLES))
    else $error("busy timer beyond its limit");
  a_wp_keeps_map: assert property (cs_rise && !wp_free |=> $stable(map[0]) && $stable(map[15]))
    else $error("map changed with write protect asserted");
  a_lock_sticky: assert property (($past(locked) & ~locked) == '0)
    else $error("a locked sector was unlocked");
  a_lock_blocks: assert property (##1 ($past(locked) & ~blocked) == '0)
    else $error("locked sector not blocked");
  a_prog_and: assert property (prog_go && data_cnt != 5'h00 |=> map[0] == $past(map[0] & staging[0]))
    else $error("map byte zero not programmed");
  a_off_unblocked: assert property (!prot_en && locked == '0 |=> blocked == '0)
    else $error("sector blocked with protection off");
  a_busy_ignores: assert property (cs_rise && !ready |=> $stable(map[3]) && $stable(locked))
    else $error("command taken while busy");

  // busy, timer and lock bits
  a_prog_busy: assert property (s_prog_start |=> s_busy_run)
    else $error("ready high too early after program");
  a_lock_busy: assert property (s_lock_start |=> s_busy_run)
    else $error("ready high too early after lockdown");
  a_lock_sets: assert property (s_lock_start |=> locked != '0)
    else $error("lockdown set no bit");
  a_ready_idle: assert property (ready |-> timer == 32'h00000000)
    else $error("timer running while ready");
  a_erase_taken: assert property (s_erase_request |=> !ready)
    else $error("erase refused with write protect free");

  // map holds between commits
  a_map_hold: assert property (!(erase_go || prog_go) |=> $stable(map[0]) && $stable(map[15]))
    else $error("map changed without a command");

  // protection view decode
  a_byte_prot: assert property (prot_en && map[2] == 8'hFF |=> blocked.sector[2])
    else $error("erased byte did not protect");
  a_byte_free: assert property (prot_en && map[2] == 8'h00 && !locked.sector[2]
                                |=> !blocked.sector[2])
    else $error("cleared byte still protects");
  a_sub0_guard: assert property (prot_en && map[0][7:6] == 2'h3 |=> blocked.first_subsector)
    else $error("first subsector not protected");
  a_sub0_free: assert property (prot_en && map[0][5:4] != 2'h3 && !locked.second_subsector
                                |=> !blocked.second_subsector)
    else $error("second subsector wrongly protected");

  // serial out floats between frames
  a_oe_idle: assert property (cs_n |-> so_oe_n)
    else $error("serial out driven with chip select high");

endmodule // sector_protect_map_commands

// file: test/spm_host.sv
// Purpose: host side of the serial link, issues map commands
// Assumes: mode 0, msb first, link clock 6 ns, still outside frames
// Notes: si shows the inverse of its last value between frames
module spm_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // one byte out on si, one byte in from so at each rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #3 sck = 1'b1;
      rx[i] = so;
      #3 sck = 1'b0;
    end
  endtask

  // whole frame, then chip select high for the idle gap
  task automatic cmd(input logic [7:0] b[$]);
    logic [7:0] rx;
    cs_n = 1'b0;
    #3;
    foreach (b[k]) xfer(b[k], rx);
    #3 cs_n = 1'b1;
    si = ~si;
    #300;
  endtask

  // opcode, three dummy bytes, then sixteen map bytes
  task automatic read_map(output logic [7:0] m[16], output logic oe);
    logic [7:0] rx;
    cs_n = 1'b0;
    #3;
    xfer(8'h32, rx);
    repeat (3) xfer(8'h00, rx);
    for (int k = 0; k < 16; k++) xfer(8'h00, m[k]);
    oe = so_oe_n;
    #3 cs_n = 1'b1;
    si = ~si;
    #300;
  endtask
endmodule // spm_host

// file: test/tb_sector_protect_map_commands.sv
// Purpose: self-checking bench for the protection map commands
// Assumes: short busy counts of 20 clk cycles
// Notes: map reads go through the host model
module tb_sector_protect_map_commands;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, wp_n, sw_protect_en, ready, sck, cs_n, si, so, so_oe_n, oe;
  spm_pkg::prot_view_t blocked, locked, ev;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] m[16];
  logic [7:0] e[16];
  logic [7:0] h[$];
  logic [7:0] d[$];

  sector_protect_map_commands #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) i_dut (
    .clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n), .wp_n(wp_n), .sw_protect_en(sw_protect_en),
    .ready(ready), .blocked(blocked), .locked(locked));
  spm_host i_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic bad(input string s);
    failures++;
    $display("unexpected at %0t: %s", $time, s);
  endtask

  task automatic chk_bit(input logic a, input logic x, input string s);
    n_tests++;
    if (a !== x) bad(s);
  endtask

  task automatic chk_view(input spm_pkg::prot_view_t a, input spm_pkg::prot_view_t x);
    n_tests++;
    if (a !== x) bad("protection view");
  endtask

  // reads the map back and compares it with e
  task automatic chk_map;
    i_host.read_map(m, oe);
    chk_bit(oe, 1'b0, "so not driven");
    chk_bit(so_oe_n, 1'b1, "so not floated");
    for (int k = 0; k < 16; k++) begin
      n_tests++;
      if (m[k] !== e[k]) bad("map byte");
    end
  endtask

  task automatic busy_cycle;
    int i;
    for (i = 0; i < 10 && ready !== 1'b0; i++) @(negedge clk);
    chk_bit(ready, 1'b0, "no busy");
    for (i = 0; i < 40 && ready !== 1'b1; i++) @(negedge clk);
    if (i == 40) begin
      bad("stuck busy");
      report_and_stop();
    end
  endtask

  task automatic t_reset;
    chk_bit(ready, 1'b1, "ready after reset");
    chk_view(blocked, '0);
    chk_view(locked, '0);
    foreach (e[k]) e[k] = 8'h00;
    chk_map();
  endtask

  task automatic t_erase;
    i_host.cmd({h, spm_pkg::OP_ERASE, 8'h55});
    busy_cycle();
    foreach (e[k]) e[k] = 8'hFF;
    chk_map();
    chk_view(blocked, '0);
  endtask

  task automatic t_program;
    @(posedge clk) sw_protect_en <= 1'b1;
    d = {h, spm_pkg::OP_PROGRAM, 8'hF0};
    for (int k = 1; k < 16; k++) d.push_back(k[0] ? 8'hFF : 8'h00);
    d.push_back(8'hC0);
    i_host.cmd(d);
    busy_cycle();
    foreach (e[k]) e[k] = k[0] ? 8'hFF : 8'h00;
    e[0] = 8'hC0;
    chk_map();
    ev = '0;
    for (int k = 1; k < 16; k++) ev.sector[k] = k[0];
    ev.first_subsector = 1'b1;
    chk_view(blocked, ev);
  endtask

  task automatic t_wp;
    @(posedge clk) wp_n <= 1'b0;
    repeat (6) @(posedge clk);
    i_host.cmd({h, spm_pkg::OP_ERASE});
    chk_bit(ready, 1'b1, "erase taken under wp");
    chk_map();
    @(posedge clk) wp_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_partial;
    i_host.cmd(h);
    chk_bit(ready, 1'b1, "short prefix taken");
    i_host.cmd({h, spm_pkg::OP_LOCK, 8'h0A, 8'h00});
    chk_bit(ready, 1'b1, "short lock taken");
    chk_view(locked, '0);
  endtask

  task automatic t_lock;
    i_host.cmd({h, spm_pkg::OP_LOCK, 8'h0A, 8'h00, 8'h00, 8'h77});
    i_host.cmd({h, spm_pkg::OP_ERASE});
    busy_cycle();
    chk_map();
    i_host.cmd({h, spm_pkg::OP_LOCK, 8'h00, 8'h06, 8'h00});
    busy_cycle();
    ev = '0;
    ev.sector[5] = 1'b1;
    ev.first_subsector = 1'b1;
    chk_view(locked, ev);
    i_host.cmd({h, spm_pkg::OP_LOCK, 8'h0A, 8'h00, 8'h00});
    busy_cycle();
    chk_view(locked, ev);
    @(posedge clk) sw_protect_en <= 1'b0;
    i_host.cmd({h, spm_pkg::OP_ERASE});
    busy_cycle();
    foreach (e[k]) e[k] = 8'hFF;
    chk_map();
    chk_view(locked, ev);
    chk_view(blocked, ev);
  endtask

  initial begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    sw_protect_en = 1'b0;
    h = {spm_pkg::OP_PREFIX0, spm_pkg::OP_PREFIX1, spm_pkg::OP_PREFIX2};
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_erase();
    t_program();
    t_wp();
    t_partial();
    t_lock();
    report_and_stop();
  end
endmodule // tb_sector_protect_map_commands
